/* File: rtl/pointer_pkg.sv */
package pointer_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [15:0] BASE_LOW_IDX = 16'h0AEE;
   localparam logic [15:0] BASE_HIGH_IDX = 16'h0EEE;
   localparam logic [15:0] X_POS_IDX = 16'h12EE;
   localparam logic [15:0] Y_POS_IDX = 16'h16EE;
   localparam logic [15:0] COLOUR_ZERO_IDX = 16'h1AEE;
   localparam logic [15:0] COLOUR_ONE_IDX = 16'h1AEF;
   localparam logic [15:0] START_COL_IDX = 16'h1EEE;
   localparam logic [15:0] START_ROW_IDX = 16'h1EEF;
   localparam logic [15:0] WIDE_ZERO_IDX = 16'h3AEE;
   localparam logic [15:0] WIDE_ONE_IDX = 16'h3EEE;
   localparam logic [15:0] STATUS_IDX = 16'h02EE;
   localparam int ADDR_W = 18;

   // field positions
   localparam int BASE_HIGH_MSB = 3;
   localparam int ENABLE_BIT = 15;
   localparam int X_FIELD_MSB = 10;
   localparam int Y_FIELD_MSB = 11;
   localparam int SKIP_MSB = 5;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ROW_BIT = 1;
   localparam int STAT_EN_BIT = 2;

   // reset values
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [7:0] REG8_RST = 8'h00;

   // bitmap geometry
   localparam int MAP_SIZE = 64;
   localparam int WORDS_PER_ROW = 8;
   localparam int PIX_PER_WORD = 8;
   localparam int X_STEP_SHIFT = 3;
   localparam int MEM_AW = 17;

   // pixel depth codes
   localparam logic [1:0] DEPTH_4 = 2'h0;
   localparam logic [1:0] DEPTH_8 = 2'h1;
   localparam logic [1:0] DEPTH_16 = 2'h2;
   localparam logic [1:0] DEPTH_24 = 2'h3;

   // pixel codes
   localparam logic [1:0] CODE_COLOUR0 = 2'h0;
   localparam logic [1:0] CODE_COLOUR1 = 2'h1;
   localparam logic [1:0] CODE_SCREEN = 2'h2;
   localparam logic [1:0] CODE_INVERT = 2'h3;

   typedef struct packed {
      logic valid;
      logic [11:0] x;
      logic [11:0] y;
      logic [23:0] data;
   } pix_t;

   typedef struct packed {
      logic req;
      logic [MEM_AW-1:0] addr;
   } mem_req_t;

   typedef enum logic {FETCH_IDLE, FETCH_RUN} fetch_state_t;
endpackage : pointer_pkg

/* File: rtl/pointer_overlay.sv */
// Behaviour
// - the cursor is any size up to 64 by 64 pixels.
// - code 00 gives colour zero, 01 colour one, 10 the screen pixel and 11 its complement.
// - bitmap rows are always 64 pixels (eight words) apart and pixels outside the area are unused.
// - within each 16-bit word the first shown pixel is the lowest bit pair.
// - the bitmap base is a 20-bit pixel count built from a 16-bit low and 4-bit high part.
// - the cursor is only overlaid while bit 15 of the high base register is one.
// - the horizontal position is an 11-bit field in steps of eight pixels.
// - the vertical position is a 12-bit field in scan lines.
// - a 6-bit column skip hides the bitmap columns before it.
// - a 6-bit row skip hides the bitmap rows before it.
// - writing position alone moves the cursor with no bitmap change.
// - the overlay works at every pixel depth.
// - at 4 bpp each colour is the low four bits of its byte register, at 8 bpp its whole 8-bit palette field.
// - at 16 and 24 bpp blue comes from the byte register, green and red from the wide register.
`timescale 1ns/1ps
module pointer_overlay (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // video memory read port
   output pointer_pkg::mem_req_t mem_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_rdata_i,
   // line announce, one pulse per line ahead of its pixels
   input wire logic line_fetch_i,
   input wire logic [11:0] line_y_i,
   // display pixel stream
   input wire logic [1:0] depth_i,
   input wire pointer_pkg::pix_t pix_i,
   output pointer_pkg::pix_t pix_o
);
   import pointer_pkg::*;

   logic [15:0] base_low_q;
   logic [15:0] base_high_q;
   logic [15:0] x_pos_q;
   logic [15:0] y_pos_q;
   logic [7:0] colour_zero_q;
   logic [7:0] colour_one_q;
   logic [7:0] start_col_q;
   logic [7:0] start_row_q;
   logic [15:0] wide_zero_q;
   logic [15:0] wide_one_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   fetch_state_t state_q;
   logic [2:0] word_q;
   logic [5:0] row_q;
   logic [11:0] row_y_q;
   logic row_ok_q;
   logic [2*MAP_SIZE-1:0] row_buf_q;
   mem_req_t mem_q;
   pix_t pix_q;

   // invert only the bits that the current depth uses
   function automatic logic [23:0] invert_at_depth(input logic [23:0] v, input logic [1:0] d);
      logic [23:0] r;
      r = v;
      case (d)
         DEPTH_4: r[3:0] = ~v[3:0];
         DEPTH_8: r[7:0] = ~v[7:0];
         DEPTH_16: r[15:0] = ~v[15:0];
         default: r = ~v;
      endcase
      return r;
   endfunction : invert_at_depth

   // colour for one cursor colour at the current depth
   function automatic logic [23:0] colour_at_depth(input logic [7:0] low_byte,
                                                   input logic [15:0] wide,
                                                   input logic [1:0] d);
      logic [23:0] r;
      r = 24'h000000;
      case (d)
         DEPTH_4: r = {20'h00000, low_byte[3:0]};
         DEPTH_8: r = {16'h0000, low_byte};
         DEPTH_16: r = {8'h00, wide[15:11], wide[7:2], low_byte[7:3]};
         default: r = {wide[15:8], wide[7:0], low_byte};
      endcase
      return r;
   endfunction : colour_at_depth

   // apb decode
   logic [15:0] idx;
   logic addr_ok;
   logic access;
   logic wr_en;
   assign idx = {2'h0, paddr_i[15:2]};
   assign access = psel_i && penable_i && pready_q;
   assign wr_en = access && pwrite_i && addr_ok;

   always_comb begin
      case (idx)
         BASE_LOW_IDX, BASE_HIGH_IDX, X_POS_IDX, Y_POS_IDX, COLOUR_ZERO_IDX,
         COLOUR_ONE_IDX, START_COL_IDX, START_ROW_IDX, WIDE_ZERO_IDX, WIDE_ONE_IDX,
         STATUS_IDX: addr_ok = (paddr_i[1:0] == 2'h0);
         default: addr_ok = 1'b0;
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= psel_i && penable_i && !pready_q;
      end
   end

   // error for unmapped addresses and writes to the status word
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= psel_i && penable_i && !pready_q &&
                      (!addr_ok || (pwrite_i && idx == STATUS_IDX));
      end
   end

   // registers are write-only; only the status word reads back
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         prdata_q <= 32'h00000000;
      end else if (psel_i && penable_i && !pready_q && !pwrite_i && addr_ok &&
                   idx == STATUS_IDX) begin
         prdata_q <= 32'h00000000;
         prdata_q[STAT_BUSY_BIT] <= (state_q == FETCH_RUN);
         prdata_q[STAT_ROW_BIT] <= row_ok_q;
         prdata_q[STAT_EN_BIT] <= base_high_q[ENABLE_BIT];
      end else begin
         prdata_q <= 32'h00000000;
      end
   end

   // merge the enabled byte lanes of a write into a sixteen-bit register
   function automatic logic [15:0] merge_lanes(input logic [15:0] cur, input logic [15:0] wd,
                                               input logic [1:0] strb);
      logic [15:0] r;
      r = cur;
      if (strb[0]) r[7:0] = wd[7:0];
      if (strb[1]) r[15:8] = wd[15:8];
      return r;
   endfunction : merge_lanes

   // bitmap base, low part
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         base_low_q <= REG16_RST;
      end else if (wr_en && idx == BASE_LOW_IDX) begin
         base_low_q <= merge_lanes(base_low_q, pwdata_i[15:0], pstrb_i[1:0]);
      end
   end

   // bitmap base, high part and enable
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         base_high_q <= REG16_RST;
      end else if (wr_en && idx == BASE_HIGH_IDX) begin
         base_high_q <= merge_lanes(base_high_q, pwdata_i[15:0], pstrb_i[1:0]);
      end
   end

   // horizontal position; a write alone moves the cursor
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         x_pos_q <= REG16_RST;
      end else if (wr_en && idx == X_POS_IDX) begin
         x_pos_q <= merge_lanes(x_pos_q, pwdata_i[15:0], pstrb_i[1:0]);
      end
   end

   // vertical position
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         y_pos_q <= REG16_RST;
      end else if (wr_en && idx == Y_POS_IDX) begin
         y_pos_q <= merge_lanes(y_pos_q, pwdata_i[15:0], pstrb_i[1:0]);
      end
   end

   // green and red of colour zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wide_zero_q <= REG16_RST;
      end else if (wr_en && idx == WIDE_ZERO_IDX) begin
         wide_zero_q <= merge_lanes(wide_zero_q, pwdata_i[15:0], pstrb_i[1:0]);
      end
   end

   // green and red of colour one
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wide_one_q <= REG16_RST;
      end else if (wr_en && idx == WIDE_ONE_IDX) begin
         wide_one_q <= merge_lanes(wide_one_q, pwdata_i[15:0], pstrb_i[1:0]);
      end
   end

   // palette colour zero, low lane only
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         colour_zero_q <= REG8_RST;
      end else if (wr_en && pstrb_i[0] && idx == COLOUR_ZERO_IDX) begin
         colour_zero_q <= pwdata_i[7:0];
      end
   end

   // palette colour one, low lane only
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         colour_one_q <= REG8_RST;
      end else if (wr_en && pstrb_i[0] && idx == COLOUR_ONE_IDX) begin
         colour_one_q <= pwdata_i[7:0];
      end
   end

   // column skip, upper bits kept but unused
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         start_col_q <= REG8_RST;
      end else if (wr_en && pstrb_i[0] && idx == START_COL_IDX) begin
         start_col_q <= pwdata_i[7:0];
      end
   end

   // row skip, upper bits kept but unused
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         start_row_q <= REG8_RST;
      end else if (wr_en && pstrb_i[0] && idx == START_ROW_IDX) begin
         start_row_q <= pwdata_i[7:0];
      end
   end

   // decoded fields
   logic enable;
   logic [19:0] base_pix;
   logic [13:0] x_left;
   logic [11:0] y_top;
   logic [5:0] col_skip;
   logic [5:0] row_skip;
   assign enable = base_high_q[ENABLE_BIT];
   assign base_pix = {base_high_q[BASE_HIGH_MSB:0], base_low_q};
   assign x_left = {x_pos_q[X_FIELD_MSB:0], 3'h0};
   assign y_top = y_pos_q[Y_FIELD_MSB:0];
   assign col_skip = start_col_q[SKIP_MSB:0];
   assign row_skip = start_row_q[SKIP_MSB:0];

   // true while a coordinate lies in the visible span; skipped bitmap rows or columns shrink it
   function automatic logic in_span(input logic [13:0] pos, input logic [13:0] origin,
                                    input logic [5:0] skip);
      logic [13:0] rel;
      rel = pos - origin;
      return (pos >= origin) && (rel < (14'(MAP_SIZE) - {8'h00, skip}));
   endfunction : in_span

   // row hit test for the announced line
   logic [11:0] line_rel;
   logic line_hit;
   logic [5:0] line_row;
   assign line_rel = line_y_i - y_top;
   assign line_hit = enable &&
                     in_span({2'h0, line_y_i}, {2'h0, y_top}, row_skip);
   assign line_row = line_rel[5:0] + row_skip;

   // word address: base in pixels, eight pixels a word, fixed 64-pixel pitch
   logic [MEM_AW-1:0] word_addr;
   assign word_addr = base_pix[19:X_STEP_SHIFT] +
                      {8'h00, row_q, word_q};

   // fetch sequencer; a new line announce restarts it so a late fetch cannot
   // leave a stale row behind, at the cost of dropping that line's cursor
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= FETCH_IDLE;
         word_q <= 3'h0;
         row_q <= 6'h00;
         row_y_q <= 12'h000;
         row_ok_q <= 1'b0;
      end else if (line_fetch_i) begin
         row_y_q <= line_y_i;
         row_q <= line_row;
         word_q <= 3'h0;
         row_ok_q <= 1'b0;
         state_q <= line_hit ? FETCH_RUN : FETCH_IDLE;
      end else begin
         case (state_q)
            FETCH_IDLE: ;
            FETCH_RUN: begin
               if (mem_ack_i && mem_q.req) begin
                  word_q <= word_q + 3'h1;
                  if (word_q == 3'(WORDS_PER_ROW - 1)) begin
                     row_ok_q <= 1'b1;
                     state_q <= FETCH_IDLE;
                  end
               end
            end
            default: state_q <= FETCH_IDLE;
         endcase
      end
   end

   // memory request held until acknowledged
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mem_q <= '0;
      end else if (line_fetch_i) begin
         mem_q <= '0;
      end else if (state_q == FETCH_RUN &&
                   !(mem_ack_i && mem_q.req && word_q == 3'(WORDS_PER_ROW - 1))) begin
         mem_q.req <= 1'b1;
         mem_q.addr <= (mem_ack_i && mem_q.req) ? word_addr + 17'h00001 : word_addr;
      end else begin
         mem_q <= '0;
      end
   end

   // row buffer: word w holds columns 8w..8w+7, lowest pair first
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         row_buf_q <= '0;
      end else if (state_q == FETCH_RUN && mem_ack_i && mem_q.req && !line_fetch_i) begin
         row_buf_q[word_q*16 +: 16] <= mem_rdata_i;
      end
   end

   // horizontal hit and code lookup
   logic [13:0] pix_rel;
   logic col_hit;
   logic [5:0] col;
   logic [1:0] code;
   assign pix_rel = {2'h0, pix_i.x} - x_left;
   assign col_hit = enable && row_ok_q && (pix_i.y == row_y_q) &&
                    in_span({2'h0, pix_i.x}, x_left, col_skip);
   assign col = pix_rel[5:0] + col_skip;
   assign code = row_buf_q[{col, 1'b0} +: 2];

   // overlay stage, one cycle of latency at every depth
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pix_q <= '0;
      end else begin
         pix_q <= pix_i;
         if (pix_i.valid && col_hit) begin
            case (code)
               CODE_COLOUR0: pix_q.data <= colour_at_depth(colour_zero_q, wide_zero_q, depth_i);
               CODE_COLOUR1: pix_q.data <= colour_at_depth(colour_one_q, wide_one_q, depth_i);
               CODE_SCREEN: pix_q.data <= pix_i.data;
               CODE_INVERT: pix_q.data <= invert_at_depth(pix_i.data, depth_i);
               default: pix_q.data <= pix_i.data;
            endcase
         end
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign mem_o = mem_q;
   assign pix_o = pix_q;
endmodule : pointer_overlay

/* File: dv/pointer_overlay_properties.sv */
`timescale 1ns/1ps
module pointer_overlay_properties
   import pointer_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // apb side
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // memory and pixel side
   input wire pointer_pkg::mem_req_t mem_o,
   input wire logic mem_ack_i,
   input wire logic line_fetch_i,
   input wire pointer_pkg::pix_t pix_i,
   input wire pointer_pkg::pix_t pix_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic en_q;
   // mirror of the enable bit, taken at the completing edge only
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         en_q <= 1'b0;
      end else if (psel_i && penable_i && pwrite_i && pready_o && !pslverr_o && pstrb_i[1]
         && paddr_i == {BASE_HIGH_IDX[13:0], 2'b00}) begin
         en_q <= pwdata_i[ENABLE_BIT];
      end
   end
   a_ready_one_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
      else $error("apb answer not after one wait state");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_write_only_zero: assert property (pready_o && paddr_i != {STATUS_IDX[13:0], 2'b00}
      |-> prdata_o == 32'h0)
      else $error("write-only register read not zero");
   a_misalign_err: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
      else $error("misaligned access not refused");
   a_pix_delay: assert property (!$past(sys_rst_i) |->
      {pix_o.valid, pix_o.x, pix_o.y} == $past({pix_i.valid, pix_i.x, pix_i.y}))
      else $error("pixel position not delayed by one");
   a_disabled_pass: assert property (!en_q && pix_i.valid |=> pix_o.data == $past(pix_i.data))
      else $error("pixel changed while cursor disabled");
   a_req_hold: assert property (mem_o.req && !mem_ack_i && !line_fetch_i
      |=> mem_o.req && $stable(mem_o.addr))
      else $error("memory request dropped before ack");
   a_addr_step: assert property (mem_o.req && mem_ack_i && !line_fetch_i ##1 mem_o.req
      |-> mem_o.addr == $past(mem_o.addr) + 1'b1)
      else $error("word address did not advance by one");
   a_no_stray_req: assert property (!mem_o.req && !line_fetch_i && !$past(line_fetch_i)
      |=> !mem_o.req)
      else $error("memory request without a line announce");
   c_mem_ack: cover property (mem_o.req && mem_ack_i);
   c_refused: cover property (pready_o && pslverr_o);
   c_overlay: cover property (pix_o.valid && en_q);
endmodule : pointer_overlay_properties

/* File: dv/video_mem_model.sv */
`timescale 1ns/1ps
module video_mem_model
   import pointer_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // read port from the overlay
   input wire pointer_pkg::mem_req_t mem_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic [15:0] rdata_o
);
   logic [15:0] store [0:(1<<MEM_AW)-1];
   logic [15:0] last_q;
   logic [1:0] wait_q;
   // one ack pulse per word, random gaps when slow
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack_o <= 1'b0;
         wait_q <= 2'h0;
      end else if (ack_o || !mem_i.req) begin
         ack_o <= 1'b0;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else begin
         ack_o <= 1'b1;
         wait_q <= slow_i ? 2'($urandom_range(3)) : 2'h0;
      end
   end
   // data lines are not held after an ack, so show the inverse
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         last_q <= 16'h0000;
      end else if (ack_o) begin
         last_q <= rdata_o;
      end
   end
   assign rdata_o = ack_o ? store[mem_i.addr] : ~last_q;
endmodule : video_mem_model

/* File: dv/tb_pointer_overlay.sv */
`timescale 1ns/1ps
module tb_pointer_overlay;
   import pointer_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, line_fetch_i = 0;
   logic slow = 0, pready_o, pslverr_o, mem_ack_i;
   logic [15:0] paddr_i = 16'h0000, mem_rdata_i, xp, yp, lo;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic [3:0] pstrb_i = 4'h3;
   logic [11:0] line_y_i = 12'h000;
   logic [1:0] depth_i = 2'h0;
   logic [3:0] hi;
   logic [5:0] cs, rs;
   pix_t pix_i = '0, pix_o;
   mem_req_t mem_o;
   int errors = 0, cmp_count = 0;
   int dy [4];
   logic [15:0] ri [10], rv [10];
   logic [15:0] sh [logic [15:0]];
   logic [32:0] apb_q [$];
   logic [47:0] pix_q [$];
   pointer_overlay pointer_overlay_i (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .mem_o, .mem_ack_i,
      .mem_rdata_i, .line_fetch_i, .line_y_i, .depth_i, .pix_i, .pix_o);
   video_mem_model video_mem_model_i (.clk_i, .sys_rst_i, .mem_i(mem_o), .slow_i(slow),
      .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   // 20 MHz clock
   always #25 clk_i = ~clk_i;
   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   // one apb transfer; the reply is noted for the monitor
   task automatic apb(input logic w, input logic [15:0] idx, input logic [1:0] ofs,
      input logic [31:0] d, input logic e, input logic [31:0] rd);
      apb_q.push_back({e, rd});
      if (w && !e) sh[idx] = d[15:0];
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {idx[13:0], ofs};
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      while (pready_o !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   // expected pixel and the mask of bits that the depth uses
   function automatic logic [47:0] expect_pix(input logic [11:0] x, y, input logic [23:0] d);
      logic [23:0] m, c;
      logic [15:0] w;
      logic [7:0] b;
      logic [1:0] code;
      int row, col;
      m = 24'hFFFFFF >> (depth_i == DEPTH_4 ? 20 : depth_i == DEPTH_8 ? 16 : depth_i[0] ? 0 : 8);
      row = int'(y) - int'(sh[Y_POS_IDX][11:0]) + int'(rs);
      col = int'(x) - 8 * int'(sh[X_POS_IDX][10:0]) + int'(cs);
      if (!sh[BASE_HIGH_IDX][ENABLE_BIT] || row < rs || row > 63 || col < cs || col > 63) begin
         return {m, d & m};
      end
      code = video_mem_model_i.store[17'({sh[BASE_HIGH_IDX][3:0], sh[BASE_LOW_IDX]} >> 3)
         + 17'(row * 8 + col / 8)][2 * (col % 8) +: 2];
      b = sh[code[0] ? COLOUR_ONE_IDX : COLOUR_ZERO_IDX][7:0];
      w = sh[code[0] ? WIDE_ONE_IDX : WIDE_ZERO_IDX];
      c = depth_i[1] ? (depth_i[0] ? {w, b} : {8'h0, w[15:11], w[7:2], b[7:3]}) : {16'h0, b};
      if (code == CODE_SCREEN) c = d;
      if (code == CODE_INVERT) c = ~d;
      return {m, c & m};
   endfunction : expect_pix
   // announce a line, let its fetch finish, then stream past both window edges
   task automatic line(input logic [11:0] y);
      logic [11:0] px;
      logic [23:0] d;
      @(posedge clk_i);
      line_fetch_i <= 1'b1;
      line_y_i <= y;
      @(posedge clk_i);
      line_fetch_i <= 1'b0;
      for (int k = 0; k < 300 && (k < 3 || mem_o.req !== 1'b0); k++) @(negedge clk_i);
      for (int x = 0; x < 80; x++) begin
         @(posedge clk_i);
         px = 12'(8 * xp - 8 + x);
         d = 24'($urandom);
         pix_i <= {1'b1, px, y, d};
         pix_q.push_back(expect_pix(px, y, d));
      end
      @(posedge clk_i);
      pix_i.valid <= 1'b0;
   endtask : line
   // take the oldest note whenever a result appears
   always @(posedge clk_i) begin
      logic [47:0] e;
      if (pready_o === 1'b1) begin
         check("apb reply", {pslverr_o, prdata_o}, apb_q.size() ? apb_q.pop_front() : 'x);
      end
      if (pix_o.valid === 1'b1) begin
         e = pix_q.size() ? pix_q.pop_front() : {24'hFFFFFF, 24'hx}; // unnoted pixel fails
         check("pixel", 33'(pix_o.data & e[47:24]), 33'(e[23:0]));
      end
   end
   initial begin
      #(50 * 60000);
      errors++;
      close_out;
   end
   initial begin
      void'($urandom(2));
      ri = '{BASE_LOW_IDX, BASE_HIGH_IDX, X_POS_IDX, Y_POS_IDX, START_COL_IDX, START_ROW_IDX,
         COLOUR_ZERO_IDX, COLOUR_ONE_IDX, WIDE_ZERO_IDX, WIDE_ONE_IDX};
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      apb(0, STATUS_IDX, 0, 0, 0, 0);
      apb(0, X_POS_IDX, 0, 0, 0, 0);
      apb(1, 16'h0001, 0, 1, 1, 0);
      apb(1, X_POS_IDX, 2'h2, 1, 1, 0);
      apb(1, STATUS_IDX, 0, 7, 1, 0);
      for (int p = 0; p < 4; p++) begin
         hi = 4'($urandom);
         lo = 16'($urandom) & 16'hFFF8;
         for (int i = 0; i < 512; i++) begin
            video_mem_model_i.store[17'({hi, lo} >> 3) + 17'(i)] = 16'($urandom);
         end
         xp = 16'($urandom_range(1, 90));
         yp = 16'($urandom_range(1, 300));
         cs = p == 1 ? 6'd63 : 6'($urandom_range(63));
         rs = p == 1 ? 6'd63 : 6'($urandom_range(63));
         rv = '{lo, {12'h800, hi}, xp, yp, 16'(cs), 16'(rs), 16'($urandom), 16'($urandom),
            16'($urandom), 16'($urandom)};
         slow <= p[0];
         depth_i <= p[1:0];
         foreach (ri[i]) apb(1, ri[i], 0, {16'h0, rv[i]}, 0, 0);
         dy = '{-1, 0, 63 - int'(rs), 64 - int'(rs)};
         foreach (dy[k]) line(12'(int'(yp) + dy[k]));
      end
      xp = xp + 16'h3;
      apb(1, X_POS_IDX, 0, {16'h0, xp}, 0, 0);
      line(12'(yp + rs[5:1]));
      apb(1, BASE_HIGH_IDX, 0, 0, 0, 0);
      line(12'(yp));
      repeat (4) @(posedge clk_i);
      check("notes left over", 33'(pix_q.size() + apb_q.size()), 33'h0);
      close_out;
   end
endmodule : tb_pointer_overlay
bind pointer_overlay pointer_overlay_properties pointer_overlay_properties_i (.clk_i,
   .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
   .pready_o, .pslverr_o, .mem_o, .mem_ack_i, .line_fetch_i, .pix_i, .pix_o);
